// ### verilog/glc_defs.vh
// Purpose: constants for the pin and led configuration block
// Assumes: 50 MHz pclk, two 32-bit registers at byte offsets 0x88 and 0x8C
// Notes: register word split into fields below
// Summary of operation
// - set led bit makes shared pin led
// - polarity set: high level sets status
// - polarity clear: low level sets status
// - status raises host_irq only when enabled; 0x8C reads show it always
// - levels shorter than 40 ns ignored
// - bits 22:20 select rom pin function
// - function encodings for data/clock pins
// - buffer bit set push-pull, clear open-drain
// - direction bit set output, clear input
// - bits 4:3 drive extra outputs a/b
// - output pin drives a written 0; a written 1 only in push-pull
// - read returns sensed pin state
`ifndef GLC_DEFS_VH
`define GLC_DEFS_VH
`define GLC_ADDR_CFG 12'h088
`define GLC_ADDR_INT 12'h08C
`define GLC_LED_LSB 28
`define GLC_POL_LSB 24
`define GLC_ROM_LSB 20
`define GLC_BUF_LSB 16
`define GLC_DIR_LSB 8
`define GLC_XO_LSB 3
`define GLC_VAL_LSB 0
`define GLC_STS_LSB 0
`define GLC_EN_LSB 4
`define GLC_CFG_MASK 32'h7777071F
`define GLC_CFG_RST 32'h00000000
`define GLC_ROM_EE 3'h0
`define GLC_ROM_AB 3'h1
`define GLC_ROM_ARX 3'h3
`define GLC_ROM_TXB 3'h5
`define GLC_ROM_TXRX 3'h6
`define GLC_ROM_CLK 3'h7
`define GLC_CLK_NS 20
`define GLC_MIN_NS 40
`define GLC_FILT_CYC ((`GLC_MIN_NS + `GLC_CLK_NS - 1) / `GLC_CLK_NS)
`endif

// ### verilog/glc_pin_config.v
// Purpose: pin direction, driver, value, led select, rom pin mux, pin events
// Assumes: apb slave, zero wait states, inputs other than gpio_in synchronous to pclk
// Notes: interrupt status/enable bits held at a second word 0x8C
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "glc_defs.vh"
module glc_pin_config (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [2:0] gpio_in,
    output reg [2:0] gpio_out,
    output reg [2:0] gpio_oe,
    input wire [2:0] led_src,
    input wire rom_data_out,
    input wire rom_data_oe,
    output reg rom_data_in,
    input wire rom_clk_out,
    input wire rx_dv,
    input wire rx_clk,
    input wire tx_en,
    input wire tx_clk,
    input wire rom_pin_data_in,
    output reg rom_pin_data_out,
    output reg rom_pin_data_oe,
    output reg rom_pin_clk_out,
    output reg rom_pin_clk_oe,
    output reg host_irq
);
    localparam SEL_ROM = 2'h0;
    localparam SEL_EXTRA = 2'h1;
    localparam SEL_MII_A = 2'h2;
    localparam SEL_MII_B = 2'h3;

    reg [31:0] cfg_q;
    reg [2:0] interrupt_status_register_q;
    reg [2:0] int_en_q;
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg [1:0] filt_q [0:2];
    reg [2:0] evt_q;
    reg [31:0] rd_mux_d;
    reg rom_pin_data_out_d;
    reg rom_pin_data_oe_d;
    reg rom_pin_clk_out_d;

    // field views of the configuration word
    wire [2:0] led_sel = cfg_q[`GLC_LED_LSB +: 3];
    wire [2:0] pol = cfg_q[`GLC_POL_LSB +: 3];
    wire [2:0] rom_fn = cfg_q[`GLC_ROM_LSB +: 3];
    wire [2:0] pushpull = cfg_q[`GLC_BUF_LSB +: 3];
    wire [2:0] dir_out = cfg_q[`GLC_DIR_LSB +: 3];
    wire [1:0] xo_val = cfg_q[`GLC_XO_LSB +: 2];
    wire [2:0] pin_val = cfg_q[`GLC_VAL_LSB +: 3];

    // bus decode; the slave never stretches a transfer
    wire setup_ph = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire rd_setup = setup_ph && !pwrite;
    wire hit_cfg = (paddr == `GLC_ADDR_CFG);
    wire hit_int = (paddr == `GLC_ADDR_INT);
    wire hit_none = !hit_cfg && !hit_int;
    wire cfg_wr = wr_en && hit_cfg;
    wire int_wr = wr_en && hit_int;

    // pin field reads the sensed level, not the stored one
    wire [31:0] cfg_rd = {cfg_q[31:3], sync2_q} & `GLC_CFG_MASK;
    wire [31:0] int_rd = ({29'h0, int_en_q} << `GLC_EN_LSB) | ({29'h0, interrupt_status_register_q} << `GLC_STS_LSB);

    // data pin source for each function code
    function [1:0] rom_data_sel;
        input [2:0] fn;
        begin
            case (fn)
                `GLC_ROM_EE: rom_data_sel = SEL_ROM;
                `GLC_ROM_AB, `GLC_ROM_ARX: rom_data_sel = SEL_EXTRA;
                `GLC_ROM_TXB, `GLC_ROM_TXRX: rom_data_sel = SEL_MII_A;
                `GLC_ROM_CLK: rom_data_sel = SEL_MII_B;
                default: rom_data_sel = SEL_ROM;
            endcase
        end
    endfunction

    // clock pin source for each function code
    function [1:0] rom_clk_sel;
        input [2:0] fn;
        begin
            case (fn)
                `GLC_ROM_EE: rom_clk_sel = SEL_ROM;
                `GLC_ROM_AB, `GLC_ROM_TXB: rom_clk_sel = SEL_EXTRA;
                `GLC_ROM_ARX, `GLC_ROM_TXRX: rom_clk_sel = SEL_MII_A;
                `GLC_ROM_CLK: rom_clk_sel = SEL_MII_B;
                default: rom_clk_sel = SEL_ROM;
            endcase
        end
    endfunction

    // apb: zero wait, unmapped reads zero and flags error
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= `GLC_CFG_RST;
            int_en_q <= 3'h0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_ph;
            pslverr <= setup_ph && hit_none;
            if (cfg_wr)
                cfg_q <= pwdata & `GLC_CFG_MASK;
            if (int_wr)
                int_en_q <= pwdata[`GLC_EN_LSB +: 3];
            if (rd_setup)
                prdata <= rd_mux_d;
        end
    end

    // read word select
    always @*
    begin
        rd_mux_d = 32'h00000000;
        if (hit_cfg)
            rd_mux_d = cfg_rd;
        else if (hit_int)
            rd_mux_d = int_rd;
    end

    genvar g;

    // first flop feeds only the second
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : sync
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= gpio_in[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    // active level must hold the filter span; led pins never raise events
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : filter
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    filt_q[g] <= 2'h0;
                    evt_q[g] <= 1'b0;
                end
                else
                begin
                    if ((sync2_q[g] == pol[g]) && !led_sel[g])
                    begin
                        if (filt_q[g] != `GLC_FILT_CYC)
                            filt_q[g] <= filt_q[g] + 2'h1;
                    end
                    else
                    begin
                        filt_q[g] <= 2'h0;
                    end
                    evt_q[g] <= (filt_q[g] == `GLC_FILT_CYC);
                end
            end
        end
    endgenerate

    // write-one clear; a new event in the same cycle wins
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : status
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    interrupt_status_register_q[g] <= 1'b0;
                else if (evt_q[g])
                    interrupt_status_register_q[g] <= 1'b1;
                else if (int_wr && pwdata[`GLC_STS_LSB + g])
                    interrupt_status_register_q[g] <= 1'b0;
            end
        end
    endgenerate

    // pin drivers
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : drive
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g] <= 1'b0;
                end
                else if (led_sel[g])
                begin
                    // led is open-drain active low
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g] <= led_src[g];
                end
                else if (dir_out[g])
                begin
                    gpio_out[g] <= pin_val[g];
                    gpio_oe[g] <= pushpull[g] | ~pin_val[g];
                end
                else
                begin
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // reserved codes fall back to rom pin outputs, rom_data_in held low; the host must avoid them
    always @*
    begin
        rom_pin_data_out_d = rom_data_out;
        rom_pin_data_oe_d = rom_data_oe;
        case (rom_data_sel(rom_fn))
            SEL_EXTRA:
            begin
                rom_pin_data_out_d = xo_val[0];
                rom_pin_data_oe_d = 1'b1;
            end
            SEL_MII_A:
            begin
                rom_pin_data_out_d = tx_en;
                rom_pin_data_oe_d = 1'b1;
            end
            SEL_MII_B:
            begin
                rom_pin_data_out_d = tx_clk;
                rom_pin_data_oe_d = 1'b1;
            end
            default:
            begin
                rom_pin_data_out_d = rom_data_out;
                rom_pin_data_oe_d = rom_data_oe;
            end
        endcase
    end

    always @*
    begin
        rom_pin_clk_out_d = rom_clk_out;
        case (rom_clk_sel(rom_fn))
            SEL_EXTRA: rom_pin_clk_out_d = xo_val[1];
            SEL_MII_A: rom_pin_clk_out_d = rx_dv;
            SEL_MII_B: rom_pin_clk_out_d = rx_clk;
            default: rom_pin_clk_out_d = rom_clk_out;
        endcase
    end

    // registered pin outputs cost one cycle of mux latency
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rom_pin_data_out <= 1'b0;
            rom_pin_data_oe <= 1'b0;
            rom_pin_clk_out <= 1'b0;
            rom_pin_clk_oe <= 1'b0;
            rom_data_in <= 1'b0;
            host_irq <= 1'b0;
        end
        else
        begin
            host_irq <= |(interrupt_status_register_q & int_en_q);
            rom_data_in <= (rom_fn == `GLC_ROM_EE) ? rom_pin_data_in : 1'b0;
            rom_pin_data_out <= rom_pin_data_out_d;
            rom_pin_data_oe <= rom_pin_data_oe_d;
            rom_pin_clk_out <= rom_pin_clk_out_d;
            rom_pin_clk_oe <= 1'b1;
        end
    end
endmodule

// ### verification/glc_pin_config_assertions.sv
// Purpose: port-level checks of the pin config block
// Assumes: config and enable words tracked from apb writes
// Notes: pin checks watch one pin each to stay short
`timescale 1ns/1ps
module glc_pin_config_assertions (
    input wire pclk, presetn, psel, penable, pwrite, pready, host_irq,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [2:0] gpio_in, gpio_out, gpio_oe, led_src,
    input wire tx_clk, rx_clk, rom_pin_data_out, rom_pin_clk_out
);
    reg [31:0] cfg_q;
    reg [2:0] en_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cfg_q <= 32'h0;
            en_q <= 3'h0;
        end
        else if (psel && penable && pwrite && pready)
        begin
            if (paddr == 12'h088) cfg_q <= pwdata & 32'h7777071F;
            if (paddr == 12'h08C) en_q <= pwdata[6:4];
        end
    // writes excluded: a clear may land late in the window
    sequence s_held;
        (en_q[0] && !cfg_q[28] && !cfg_q[8] && !(psel && pwrite) && gpio_in[0] == cfg_q[24]) [*8];
    endsequence
    sequence s_calm_read;
        ($stable(gpio_in) && $stable(cfg_q)) [*4] ##0 (pready && !pwrite && paddr == 12'h088);
    endsequence
    a_out_drive: assert property ($stable(cfg_q) && !cfg_q[28] && cfg_q[8] && cfg_q[16]
        |-> gpio_oe[0] && gpio_out[0] == cfg_q[0]) else $error("pin drive wrong");
    a_od_release: assert property ($stable(cfg_q) && !cfg_q[28] && !cfg_q[16] && cfg_q[0]
        |-> !gpio_oe[0]) else $error("open drain drives high");
    a_led_sink: assert property ($stable(cfg_q) && $stable(led_src) && cfg_q[29] && led_src[1]
        |-> gpio_oe[1] && !gpio_out[1]) else $error("led pin not sunk");
    a_rom_extra: assert property ($stable(cfg_q) && cfg_q[22:20] == 3'h1
        |-> rom_pin_data_out == cfg_q[3] && rom_pin_clk_out == cfg_q[4]) else $error("extra outputs wrong");
    a_rom_mii: assert property ($stable(cfg_q) && cfg_q[22:20] == 3'h7
        |-> rom_pin_data_out == $past(tx_clk) && rom_pin_clk_out == $past(rx_clk)) else $error("clock mux wrong");
    a_irq_gate: assert property ($stable(en_q) && en_q == 3'h0 |-> !host_irq)
        else $error("irq while disabled");
    a_evt_irq: assert property (s_held |-> host_irq)
        else $error("held level gave no irq");
    a_read_pins: assert property (s_calm_read |-> prdata == {cfg_q[31:3], gpio_in})
        else $error("read back wrong");
endmodule

// ### verification/glc_pin_model.sv
// Purpose: pins with pull-ups and an outside driver
// Assumes: every pin has a pull-up
// Notes: outside driver is only used on input pins
`timescale 1ns/1ps
module glc_pin_model (
    input wire [2:0] gpio_out, gpio_oe, ext_oe, ext_val,
    input wire rom_pin_data_out, rom_pin_data_oe,
    output wire [2:0] gpio_in,
    output wire rom_pin_data_in
);
    // released lines float up, so open drain reads high
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ~(ext_oe & ~ext_val));
    assign rom_pin_data_in = rom_pin_data_oe ? rom_pin_data_out : 1'h1;
endmodule

// ### verification/gpio_led_pin_config_tb_top.sv
// Purpose: self-checking bench for the pin config block
// Assumes: zero wait apb, one idle cycle between transfers
// Notes: reads are checked by a monitor against a queue
`timescale 1ns/1ps
module gpio_led_pin_config_tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg rx_dv = 0, rx_clk = 0, tx_en = 0, tx_clk = 0, rom_data_out = 0, rom_data_oe = 0, rom_clk_out = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, c;
    reg [2:0] led_src = 0, ext_oe = 0, ext_val = 0;
    reg [32:0] q[$], e, last;
    wire [31:0] prdata;
    wire pready, pslverr, host_irq, rom_data_in, rom_pin_data_in;
    wire rom_pin_data_out, rom_pin_data_oe, rom_pin_clk_out, rom_pin_clk_oe;
    wire [2:0] gpio_in, gpio_out, gpio_oe;
    integer errors = 0, cmp_count = 0, seed = 13, i;
    glc_pin_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .led_src(led_src), .rom_data_out(rom_data_out),
        .rom_data_oe(rom_data_oe), .rom_data_in(rom_data_in), .rom_clk_out(rom_clk_out), .rx_dv(rx_dv),
        .rx_clk(rx_clk), .tx_en(tx_en), .tx_clk(tx_clk), .rom_pin_data_in(rom_pin_data_in),
        .rom_pin_data_out(rom_pin_data_out), .rom_pin_data_oe(rom_pin_data_oe), .rom_pin_clk_out(rom_pin_clk_out),
        .rom_pin_clk_oe(rom_pin_clk_oe), .host_irq(host_irq));
    glc_pin_model i_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_oe(ext_oe), .ext_val(ext_val),
        .rom_pin_data_out(rom_pin_data_out), .rom_pin_data_oe(rom_pin_data_oe), .gpio_in(gpio_in),
        .rom_pin_data_in(rom_pin_data_in));
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) {rx_dv, rx_clk, tx_en, tx_clk, rom_data_out, rom_data_oe, rom_clk_out} <= $random(seed);
    function [2:0] pins(input [31:0] v, input [2:0] l);
        integer k;
        for (k = 0; k < 3; k = k + 1) pins[k] = v[28 + k] ? !l[k] : (v[8 + k] ? v[k] : 1'h1);
    endfunction
    task xfer(input [11:0] a, input w, input [31:0] d, input [32:0] x);
    begin
        if (!w) q.push_back(x);
        @(posedge pclk);
        {psel, penable, paddr, pwrite, pwdata} <= {1'h1, 1'h0, a, w, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        {psel, penable} <= 2'h0;
    end
    endtask
    always @(posedge pclk) if (psel && penable && pready && !pwrite)
    begin
        e = q.pop_front();
        cmp_count = cmp_count + 1;
        if (pslverr !== e[32] || (!e[32] && prdata !== e[31:0]))
        begin
            errors = errors + 1;
            $display("ERROR read %h expected %h seen %h", paddr, e, {pslverr, prdata});
        end
    end
    task final_report;
    begin
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #50000 errors = errors + 1;
        final_report;
    end
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        xfer(12'h088, 0, 0, {1'h0, 32'h7});
        for (i = 0; i < 12; i = i + 1)
        begin
            c = $random(seed);
            c[22:20] = 18'h01777 >> (3 * (i % 6)); // reserved codes never written
            led_src <= $random(seed);
            xfer(12'h088, 1, c, 0);
            repeat (5) @(posedge pclk);
            last = {1'h0, c[31:3] & 29'h0EEEE0E3, pins(c, led_src)};
            xfer(12'h088, 0, 0, last);
        end
        xfer(12'h090, 1, 32'hFFFFFFFF, 0);
        xfer(12'h090, 0, 0, {1'h1, 32'h0});
        xfer(12'h088, 0, 0, last);
        led_src <= 0;
        xfer(12'h088, 1, 0, 0);
        // let events from the random configurations drain before clearing
        repeat (8) @(posedge pclk);
        xfer(12'h08C, 1, 32'h77, 0);
        repeat (6) @(posedge pclk);
        xfer(12'h08C, 0, 0, {1'h0, 32'h70});
        {ext_oe, ext_val} <= 6'h08;
        @(posedge pclk) ext_oe <= 0;
        repeat (6) @(posedge pclk);
        xfer(12'h08C, 0, 0, {1'h0, 32'h70}); // short pulse ignored
        ext_oe <= 1;
        repeat (8) @(posedge pclk);
        xfer(12'h08C, 0, 0, {1'h0, 32'h71});
        ext_oe <= 0;
        xfer(12'h088, 1, 32'h05000000, 0);
        repeat (10) @(posedge pclk);
        xfer(12'h08C, 0, 0, {1'h0, 32'h75});
        xfer(12'h08C, 1, 0, 0);
        repeat (4) @(posedge pclk);
        xfer(12'h08C, 0, 0, {1'h0, 32'h05});
        final_report;
    end
endmodule
bind glc_pin_config glc_pin_config_assertions i_chk (.*);
